// >>> rtl/cctm_pkg.sv
// constants, encodings and carrier types for the consumer and timing-mode mailbox block
package cctm_pkg;
	localparam int NMBOX = 8;
	localparam logic [11:0] OFS_CTRL_MODE = 12'h000;
	localparam logic [11:0] OFS_IRQ_EN = 12'h004;
	localparam logic [11:0] OFS_IRQ_DIS = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFS_CTRL_STAT = 12'h010;
	localparam logic [11:0] OFS_FREE_CNT = 12'h018;
	localparam logic [11:0] OFS_STAMP = 12'h01c;
	localparam logic [11:0] OFS_XFER_CMD = 12'h024;
	// mailbox x sits at 0x200 + 0x20*x; word index within the mailbox in addr[4:2]
	localparam logic [3:0] MBOX_PAGE = 4'h2;
	localparam logic [2:0] MW_MODE = 3'h0;
	localparam logic [2:0] MW_STAT = 3'h4;
	localparam logic [2:0] MW_DLO = 3'h5;
	localparam logic [2:0] MW_DHI = 3'h6;
	localparam logic [2:0] MW_CTRL = 3'h7;
	localparam int CM_CAP_END = 4;
	localparam int CM_TIME_TRIG = 5;
	localparam int CM_FREEZE = 6;
	localparam int CM_NO_REPEAT = 7;
	localparam logic [7:0] CM_IMPL = 8'hf0;
	localparam int IRQ_FROZEN = 22;
	localparam logic [31:0] IRQ_IMPL = 32'h0040_00ff;
	localparam int ST_ABORT = 22;
	localparam int ST_READY = 23;
	localparam int ST_LOST = 24;
	localparam int CTL_REMOTE = 20;
	localparam int CTL_XFER = 23;
	localparam int XC_CNT_RST = 31;
	localparam int MODE_OBJ_LSB = 24;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {
		OBJ_OFF = 3'h0,
		OBJ_RX = 3'h1,
		OBJ_RX_OVR = 3'h2,
		OBJ_TX = 3'h3,
		OBJ_CONSUMER = 3'h4,
		OBJ_PRODUCER = 3'h5
	} cctm_obj_t;
	// events from the frame engine, same clock: sof, eof, tx_done, arb_lost, rx_hit are one-cycle pulses, tick counts once per cycle it is high
	typedef struct packed {
		logic sof;
		logic eof;
		logic tick;
		logic tx_done;
		logic arb_lost;
		logic rx_hit;
		logic [2:0] mbox;
		logic [63:0] data;
	} cctm_link_t;
endpackage : cctm_pkg

// >>> rtl/cctm_core.sv
// consumer mailboxes, free counter, timestamps and time-triggered gating behind axi4-lite
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cctm_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire cctm_pkg::cctm_link_t link,
	output logic [7:0] tx_req,
	output logic [7:0] tx_remote,
	output logic can_irq
);
	localparam int N = cctm_pkg::NMBOX;

	function automatic logic is_mbox(input logic [11:0] a);
		return a[11:8] == cctm_pkg::MBOX_PAGE;
	endfunction : is_mbox

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	// axi state
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
	logic rvalid_q, rvalid_d;
	logic [11:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d, w_mask_q, w_mask_d, rdata_q, rdata_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic do_wr, do_rd;

	// core state
	logic [7:0] cfg_q, cfg_d;
	logic [31:0] imask_q, imask_d;
	logic [15:0] cnt_q, cnt_d, stamp_q, stamp_d;
	logic frozen_q, frozen_d;
	logic [N-1:0] ready_q, ready_d, ready_prev_q, lost_q, lost_d, abort_q, abort_d;
	logic [N-1:0] pend_q, pend_d, trig_q, trig_d, armed_q, armed_d;
	cctm_pkg::cctm_obj_t obj_q [N];
	cctm_pkg::cctm_obj_t obj_d [N];
	logic [15:0] mark_q [N];
	logic [15:0] mark_d [N];
	logic [15:0] mstamp_q [N];
	logic [15:0] mstamp_d [N];
	logic [31:0] dlo_q [N];
	logic [31:0] dlo_d [N];
	logic [31:0] dhi_q [N];
	logic [31:0] dhi_d [N];

	// helpers read by the checks below as well
	logic [N-1:0] rdy_rise, tm_event, cmd_v, cons_en, store_v, discard_v, stat_rd;
	logic time_trig, cap_end, freeze, no_repeat, cnt_rst, stat_g_rd;
	logic [2:0] w_idx, r_idx;
	logic [31:0] wmask;

	assign time_trig = cfg_q[cctm_pkg::CM_TIME_TRIG];
	assign cap_end = cfg_q[cctm_pkg::CM_CAP_END];
	assign freeze = cfg_q[cctm_pkg::CM_FREEZE];
	assign no_repeat = cfg_q[cctm_pkg::CM_NO_REPEAT];
	assign w_idx = aw_addr_q[7:5];
	assign r_idx = s_axi_araddr[7:5];
	assign rdy_rise = ready_q & ~ready_prev_q;

	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign do_wr = aw_have_q && w_have_q && !bvalid_q;
	assign do_rd = s_axi_arvalid && !rvalid_q;

	// bus slave: write address and data taken in either order, response after both
	always_comb
	begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d = w_have_q;
		w_data_d = w_data_q;
		w_mask_d = w_mask_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_mask_d = lane_mask(s_axi_wstrb);
		end
		if (do_wr)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = cctm_pkg::RESP_OKAY;
			if (!is_mbox(aw_addr_q) && aw_addr_q != cctm_pkg::OFS_CTRL_MODE &&
				aw_addr_q != cctm_pkg::OFS_IRQ_EN && aw_addr_q != cctm_pkg::OFS_IRQ_DIS &&
				aw_addr_q != cctm_pkg::OFS_XFER_CMD)
				bresp_d = cctm_pkg::RESP_DECERR;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (do_rd)
		begin
			rvalid_d = 1'b1;
			rresp_d = cctm_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (is_mbox(s_axi_araddr))
			begin
				case (s_axi_araddr[4:2])
					cctm_pkg::MW_MODE: rdata_d = {5'h00, obj_q[r_idx], 8'h00, mark_q[r_idx]};
					cctm_pkg::MW_STAT:
					begin
						rdata_d[cctm_pkg::ST_ABORT] = abort_q[r_idx];
						rdata_d[cctm_pkg::ST_READY] = ready_q[r_idx];
						rdata_d[cctm_pkg::ST_LOST] = lost_q[r_idx];
						rdata_d[15:0] = time_trig ? 16'h0000 : mstamp_q[r_idx];
					end
					cctm_pkg::MW_DLO: rdata_d = dlo_q[r_idx];
					cctm_pkg::MW_DHI: rdata_d = dhi_q[r_idx];
					default: rdata_d = 32'h0000_0000;
				endcase
			end
			else
			begin
				case (s_axi_araddr)
					cctm_pkg::OFS_CTRL_MODE: rdata_d = {24'h00_0000, cfg_q};
					cctm_pkg::OFS_IRQ_MASK: rdata_d = imask_q;
					cctm_pkg::OFS_CTRL_STAT: rdata_d[cctm_pkg::IRQ_FROZEN] = frozen_q;
					cctm_pkg::OFS_FREE_CNT: rdata_d = {16'h0000, cnt_q};
					cctm_pkg::OFS_STAMP: rdata_d = {16'h0000, stamp_q};
					cctm_pkg::OFS_IRQ_EN, cctm_pkg::OFS_IRQ_DIS, cctm_pkg::OFS_XFER_CMD:
						rdata_d = 32'h0000_0000;
					default: rresp_d = cctm_pkg::RESP_DECERR;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_mask_q <= 32'h0000_0000;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q <= w_have_d;
			w_data_q <= w_data_d;
			w_mask_q <= w_mask_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// mailbox and counter logic
	always_comb
	begin
		wmask = w_mask_q;
		cfg_d = cfg_q;
		imask_d = imask_q;
		cnt_d = cnt_q;
		stamp_d = stamp_q;
		frozen_d = frozen_q;
		ready_d = ready_q;
		lost_d = lost_q;
		abort_d = abort_q;
		pend_d = pend_q;
		trig_d = trig_q;
		armed_d = armed_q;
		obj_d = obj_q;
		mark_d = mark_q;
		mstamp_d = mstamp_q;
		dlo_d = dlo_q;
		dhi_d = dhi_q;
		tm_event = '0;
		cmd_v = '0;
		cons_en = '0;
		store_v = '0;
		discard_v = '0;
		stat_rd = '0;
		stat_g_rd = do_rd && s_axi_araddr == cctm_pkg::OFS_CTRL_STAT;
		if (do_wr && aw_addr_q == cctm_pkg::OFS_CTRL_MODE)
			cfg_d = (cfg_q & ~(wmask[7:0] & cctm_pkg::CM_IMPL)) |
				(w_data_q[7:0] & wmask[7:0] & cctm_pkg::CM_IMPL);
		if (do_wr && aw_addr_q == cctm_pkg::OFS_IRQ_EN)
			imask_d = imask_q | (w_data_q & wmask & cctm_pkg::IRQ_IMPL);
		if (do_wr && aw_addr_q == cctm_pkg::OFS_IRQ_DIS)
			imask_d = imask_q & ~(w_data_q & wmask);
		if (do_wr && aw_addr_q == cctm_pkg::OFS_XFER_CMD)
			cmd_v = w_data_q[N-1:0] & wmask[N-1:0];
		// capture instant picked by the frame-end setting
		if ((link.sof && !cap_end) || (link.eof && cap_end))
			stamp_d = cnt_q;
		// counter reset: reference frame in the last mailbox, or software
		cnt_rst = (time_trig && rdy_rise[N-1]) ||
			(do_wr && aw_addr_q == cctm_pkg::OFS_XFER_CMD &&
			w_data_q[cctm_pkg::XC_CNT_RST] && wmask[cctm_pkg::XC_CNT_RST]);
		if (cnt_rst)
			cnt_d = cctm_pkg::CNT_RESET;
		else if (link.tick)
		begin
			if (freeze && cnt_q == cctm_pkg::CNT_MAX)
				frozen_d = 1'b1;
			else
				cnt_d = cnt_q + 16'h0001;
		end
		if (stat_g_rd && !(link.tick && freeze && cnt_q == cctm_pkg::CNT_MAX && !cnt_rst))
			frozen_d = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			stat_rd[i] = do_rd && is_mbox(s_axi_araddr) && r_idx == 3'(i) &&
				s_axi_araddr[4:2] == cctm_pkg::MW_STAT;
			if (stat_rd[i])
				lost_d[i] = 1'b0;
			if (link.tick && cnt_q == mark_q[i])
			begin
				tm_event[i] = 1'b1;
				trig_d[i] = 1'b1;
			end
			if (do_wr && is_mbox(aw_addr_q) && w_idx == 3'(i))
			begin
				case (aw_addr_q[4:2])
					cctm_pkg::MW_MODE:
					begin
						obj_d[i] = cctm_pkg::cctm_obj_t'(w_data_q[cctm_pkg::MODE_OBJ_LSB +: 3]);
						mark_d[i] = w_data_q[15:0];
						pend_d[i] = 1'b0;
						armed_d[i] = 1'b0;
						abort_d[i] = 1'b0;
						ready_d[i] = obj_d[i] == cctm_pkg::OBJ_TX ||
							obj_d[i] == cctm_pkg::OBJ_PRODUCER;
						cons_en[i] = obj_d[i] == cctm_pkg::OBJ_CONSUMER;
					end
					cctm_pkg::MW_DLO: dlo_d[i] = (dlo_q[i] & ~wmask) | (w_data_q & wmask);
					cctm_pkg::MW_DHI: dhi_d[i] = (dhi_q[i] & ~wmask) | (w_data_q & wmask);
					// remote-request bit has no say in consumer operation
					cctm_pkg::MW_CTRL: cmd_v[i] = cmd_v[i] |
						(w_data_q[cctm_pkg::CTL_XFER] & wmask[cctm_pkg::CTL_XFER]);
					default: ;
				endcase
			end
			if (cmd_v[i] && (obj_q[i] == cctm_pkg::OBJ_TX || obj_q[i] == cctm_pkg::OBJ_CONSUMER ||
				obj_q[i] == cctm_pkg::OBJ_PRODUCER))
			begin
				pend_d[i] = 1'b1;
				ready_d[i] = 1'b0;
				abort_d[i] = 1'b0;
				armed_d[i] = 1'b0;
				trig_d[i] = 1'b0;
			end
			if (link.mbox == 3'(i) && link.tx_done && pend_q[i])
			begin
				pend_d[i] = 1'b0;
				trig_d[i] = 1'b0;
				mstamp_d[i] = stamp_d;
				if (obj_q[i] == cctm_pkg::OBJ_CONSUMER)
					armed_d[i] = 1'b1;
				else
					ready_d[i] = 1'b1;
			end
			if (link.mbox == 3'(i) && link.arb_lost && pend_q[i])
			begin
				if (no_repeat)
				begin
					pend_d[i] = 1'b0;
					abort_d[i] = 1'b1;
					ready_d[i] = 1'b1;
				end
				else if (time_trig)
					trig_d[i] = 1'b0;
			end
			// first answer kept; later matches while ready is set are dropped, except in OBJ_RX_OVR mailboxes, which overwrite
			if (link.mbox == 3'(i) && link.rx_hit && ((obj_q[i] == cctm_pkg::OBJ_CONSUMER &&
				armed_q[i]) || obj_q[i] == cctm_pkg::OBJ_RX || obj_q[i] == cctm_pkg::OBJ_RX_OVR))
			begin
				if (ready_q[i])
				begin
					discard_v[i] = 1'b1;
					lost_d[i] = 1'b1;
				end
				if (!ready_q[i] || obj_q[i] == cctm_pkg::OBJ_RX_OVR)
				begin
					store_v[i] = 1'b1;
					ready_d[i] = 1'b1;
					dlo_d[i] = link.data[31:0];
					dhi_d[i] = link.data[63:32];
					mstamp_d[i] = stamp_d;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_q <= 8'h00;
			imask_q <= 32'h0000_0000;
			cnt_q <= cctm_pkg::CNT_RESET;
			stamp_q <= cctm_pkg::CNT_RESET;
			frozen_q <= 1'b0;
			ready_q <= '0;
			ready_prev_q <= '0;
			lost_q <= '0;
			abort_q <= '0;
			pend_q <= '0;
			trig_q <= '0;
			armed_q <= '0;
			for (int i = 0; i < N; i++)
			begin
				obj_q[i] <= cctm_pkg::OBJ_OFF;
				mark_q[i] <= 16'h0000;
				mstamp_q[i] <= 16'h0000;
				dlo_q[i] <= 32'h0000_0000;
				dhi_q[i] <= 32'h0000_0000;
			end
		end
		else
		begin
			cfg_q <= cfg_d;
			imask_q <= imask_d;
			cnt_q <= cnt_d;
			stamp_q <= stamp_d;
			frozen_q <= frozen_d;
			ready_q <= ready_d;
			ready_prev_q <= ready_q;
			lost_q <= lost_d;
			abort_q <= abort_d;
			pend_q <= pend_d;
			trig_q <= trig_d;
			armed_q <= armed_d;
			obj_q <= obj_d;
			mark_q <= mark_d;
			mstamp_q <= mstamp_d;
			dlo_q <= dlo_d;
			dhi_q <= dhi_d;
		end
	end

	// consumer mailboxes ask for a remote frame; time-triggered requests wait for the mark
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			tx_req[i] = pend_q[i] && (!time_trig || trig_q[i]);
			tx_remote[i] = obj_q[i] == cctm_pkg::OBJ_CONSUMER;
		end
	end

	assign can_irq = |(ready_q & imask_q[N-1:0]) ||
		(frozen_q && imask_q[cctm_pkg::IRQ_FROZEN]);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_freeze;
		link.tick && freeze && cnt_q == cctm_pkg::CNT_MAX && !cnt_rst;
	endsequence
	sequence s_held_frozen;
		cnt_q == cctm_pkg::CNT_MAX && frozen_q;
	endsequence

	cons_ready_clear_a: assert property (cons_en != '0 |=> (ready_q & $past(cons_en)) == '0)
		else $error("consumer enable left ready set");
	xfer_pend_a: assert property (cmd_v != '0 && !link.tx_done && !link.arb_lost |=>
		(pend_q & $past(cmd_v & tx_remote)) == $past(cmd_v & tx_remote))
		else $error("transfer command did not pend consumer mailboxes");
	answer_store_a: assert property (store_v != '0 |=> (ready_q & $past(store_v)) ==
		$past(store_v) && dlo_q[$past(link.mbox)] == $past(link.data[31:0]))
		else $error("answer not stored with ready");
	mbox_irq_a: assert property ((ready_q & imask_q[N-1:0]) != '0 |-> can_irq)
		else $error("pending mailbox gave no interrupt");
	lost_set_a: assert property ((discard_v & ~store_v) != '0 |=>
		(lost_q & $past(discard_v)) == $past(discard_v) &&
		dlo_q[$past(link.mbox)] == $past(dlo_q[link.mbox]))
		else $error("discard did not raise lost or changed data");
	lost_clear_a: assert property (stat_rd != '0 && discard_v == '0 |=>
		(lost_q & $past(stat_rd)) == '0)
		else $error("status read left lost set");
	cnt_step_a: assert property (link.tick && !cnt_rst &&
		!(freeze && cnt_q == cctm_pkg::CNT_MAX) |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not step");
	ref_reset_a: assert property (time_trig && rdy_rise[N-1] |=> cnt_q == cctm_pkg::CNT_RESET)
		else $error("reference frame did not reset counter");
	freeze_hold_a: assert property (s_freeze |=> s_held_frozen)
		else $error("counter not frozen with flag");
	frozen_clear_a: assert property (stat_g_rd && !link.tick |=> !frozen_q)
		else $error("status read left frozen flag");
	trig_gate_a: assert property (time_trig |-> (tx_req & ~trig_q) == '0)
		else $error("time-triggered request sent before its mark");
	stamp_zero_a: assert property (do_rd && time_trig && is_mbox(s_axi_araddr) &&
		s_axi_araddr[4:2] == cctm_pkg::MW_STAT |=> s_axi_rdata[15:0] == 16'h0000)
		else $error("mailbox stamp visible in time-triggered operation");
	stamp_take_a: assert property ((link.sof && !cap_end) || (link.eof && cap_end) |=>
		stamp_q == $past(cnt_q))
		else $error("stamp register missed its capture instant");
	stamp_keep_a: assert property (!((link.sof && !cap_end) || (link.eof && cap_end)) |=>
		$stable(stamp_q))
		else $error("stamp register captured off its instant");
endmodule : cctm_core

// >>> dv/cctm_node_model.sv
// behavioural model of the other bus nodes as seen through the frame engine pulses
`timescale 1ns/1ps
module cctm_node_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] tx_req,
	input wire logic [7:0] tx_remote,
	input wire logic tick_en,
	input wire logic lose,
	input wire logic inj,
	input wire logic [2:0] inj_mb,
	input wire logic [63:0] ans,
	output cctm_pkg::cctm_link_t link
);
	logic [2:0] step_q;
	logic [2:0] mb_q;
	logic [2:0] lo;
	logic rx_q;
	logic ans_go;
	// lowest number is served first, so a consumer must sit below its overwrite mailbox
	always_comb
	begin
		lo = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (tx_req[i])
				lo = 3'(i);
	end
	// a remote frame that got through is answered by the producer
	assign ans_go = !rx_q && !lose && tx_remote[mb_q];
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link <= '0;
			step_q <= 3'h0;
			mb_q <= 3'h0;
			rx_q <= 1'b0;
		end
		else
		begin
			link.sof <= (step_q == 3'h0 && (inj || |tx_req)) || step_q == 3'h5;
			link.eof <= step_q == 3'h4;
			link.tick <= tick_en;
			link.rx_hit <= step_q == 3'h3 && rx_q;
			link.arb_lost <= step_q == 3'h3 && !rx_q && lose;
			link.tx_done <= step_q == 3'h3 && !rx_q && !lose;
			link.mbox <= mb_q;
			// unqualified payload keeps moving so a stale word never passes for data
			link.data <= (step_q == 3'h3 && rx_q) ? ans : ~link.data;
			case (step_q)
			3'h0:
				if (inj || |tx_req)
				begin
					mb_q <= inj ? inj_mb : lo;
					rx_q <= inj;
					step_q <= 3'h1;
				end
			3'h4:
			begin
				rx_q <= ans_go;
				step_q <= ans_go ? 3'h5 : 3'h0;
			end
			3'h5:
				step_q <= 3'h1;
			default:
				step_q <= step_q + 3'h1;
			endcase
		end
	end
endmodule : cctm_node_model

// >>> dv/can_consumer_and_timing_modes_tb_top.sv
// self-checking testbench for the consumer and timing-mode mailbox block
`timescale 1ns/1ps
module can_consumer_and_timing_modes_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'hf;
	logic awr, wrd, bv, arr, rv, can_irq;
	logic [1:0] bresp, rresp, rs, bs;
	logic [31:0] rdata, rd_v;
	logic [7:0] tx_req, tx_remote;
	logic tick_en = 1'b0, lose = 1'b0, inj = 1'b0;
	logic [2:0] inj_mb = 3'h0, c;
	logic [63:0] ans = 64'h0, d;
	logic [15:0] n, m;
	cctm_pkg::cctm_link_t link;
	int err_total = 0, n_compared = 0, cyc = 0;
	cctm_core u_dut (.clk(clk), .rst_n(rst_n),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.link(link), .tx_req(tx_req), .tx_remote(tx_remote), .can_irq(can_irq));
	cctm_node_model u_node (.clk(clk), .rst_n(rst_n), .tx_req(tx_req), .tx_remote(tx_remote),
		.tick_en(tick_en), .lose(lose), .inj(inj), .inj_mb(inj_mb), .ans(ans), .link(link));
	always #2.5 clk = ~clk;
	task automatic end_of_test;
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// the freeze run alone needs some 65600 cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			err_total++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk
	function automatic logic [11:0] ma(input logic [2:0] mb, input logic [2:0] w);
		return {cctm_pkg::MBOX_PAGE, mb, w, 2'b00};
	endfunction : ma
	function automatic logic [31:0] mode_w(input cctm_pkg::cctm_obj_t o, input logic [15:0] k);
		return {5'h0, o, 8'h0, k};
	endfunction : mode_w
	// handshakes are judged just before the edge, so no edge race with the slave
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic ta, tw, b;
		b = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!b)
		begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wrd;
			b = bv;
			bs = bresp;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			if (b)
				br <= 1'b0;
		end
	endtask : wr
	task automatic rd(input logic [11:0] a);
		logic ta, r;
		r = 1'b0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!r)
		begin
			@(negedge clk);
			ta = arv && arr;
			r = rv;
			rd_v = rdata;
			rs = rresp;
			@(posedge clk);
			if (ta)
				arv <= 1'b0;
			if (r)
				rr <= 1'b0;
		end
	endtask : rd
	// exact tick counts keep every counter and stamp value predictable
	task automatic pulse(input logic [15:0] k);
		@(posedge clk);
		tick_en <= 1'b1;
		repeat (k) @(posedge clk);
		tick_en <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic inject(input logic [2:0] mb, input logic [63:0] v);
		@(posedge clk);
		inj <= 1'b1;
		inj_mb <= mb;
		ans <= v;
		@(posedge clk);
		inj <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : inject
	task automatic st(input logic [2:0] mb);
		repeat (10) @(posedge clk);
		rd(ma(mb, cctm_pkg::MW_STAT));
	endtask : st
	initial
	begin
		void'($urandom(32'ha66f));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h100);
		chk("unmapped resp", 32'(cctm_pkg::RESP_DECERR), 32'(rs));
		chk("unmapped data", 32'h0, rd_v);
		wr(12'h100, 32'h0);
		chk("unmapped write resp", 32'(cctm_pkg::RESP_DECERR), 32'(bs));
		n = 16'($urandom_range(40, 3));
		pulse(n);
		rd(cctm_pkg::OFS_FREE_CNT);
		chk("counter step", 32'(n), rd_v);
		c = 3'($urandom_range(5, 0));
		d = {$urandom, $urandom};
		ans <= d;
		wr(ma(c, cctm_pkg::MW_MODE), mode_w(cctm_pkg::OBJ_CONSUMER, 16'h0));
		chk("mode write resp", 32'(cctm_pkg::RESP_OKAY), 32'(bs));
		chk("remote frame", 32'h1, 32'(tx_remote[c]));
		rd(ma(c, cctm_pkg::MW_STAT));
		chk("consumer ready", 32'h0, 32'(rd_v[cctm_pkg::ST_READY]));
		wr(cctm_pkg::OFS_IRQ_EN, 32'h1 << c);
		wr(ma(c, cctm_pkg::MW_CTRL), 32'h0090_0000);
		st(c);
		repeat (4) st(c);
		chk("answer ready", 32'h1, 32'(rd_v[cctm_pkg::ST_READY]));
		chk("mailbox stamp", 32'(n), 32'(rd_v[15:0]));
		rd(cctm_pkg::OFS_STAMP);
		chk("stamp register", 32'(n), rd_v);
		rd(ma(c, cctm_pkg::MW_DLO));
		chk("data low", d[31:0], rd_v);
		rd(ma(c, cctm_pkg::MW_DHI));
		chk("data high", d[63:32], rd_v);
		chk("irq pending", 32'h1, 32'(can_irq));
		wr(cctm_pkg::OFS_IRQ_DIS, 32'h1 << c);
		chk("irq masked", 32'h0, 32'(can_irq));
		inject(c, ~d);
		rd(ma(c, cctm_pkg::MW_STAT));
		chk("lost set", 32'h1, 32'(rd_v[cctm_pkg::ST_LOST]));
		rd(ma(c, cctm_pkg::MW_STAT));
		chk("lost cleared", 32'h0, 32'(rd_v[cctm_pkg::ST_LOST]));
		rd(ma(c, cctm_pkg::MW_DLO));
		chk("first kept", d[31:0], rd_v);
		wr(ma(3'h6, cctm_pkg::MW_MODE), mode_w(cctm_pkg::OBJ_TX, 16'h0));
		wr(ma(3'h7, cctm_pkg::MW_MODE), mode_w(cctm_pkg::OBJ_TX, 16'h0));
		wr(cctm_pkg::OFS_XFER_CMD, 32'h0000_00c0);
		chk("both requested", 32'h0000_00c0, 32'(tx_req & 8'hc0));
		repeat (30) @(posedge clk);
		m = 16'($urandom_range(30, 8));
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h1 << cctm_pkg::CM_TIME_TRIG);
		wr(ma(3'h7, cctm_pkg::MW_MODE), mode_w(cctm_pkg::OBJ_RX, 16'h0));
		wr(ma(3'h6, cctm_pkg::MW_MODE), mode_w(cctm_pkg::OBJ_TX, m));
		wr(cctm_pkg::OFS_XFER_CMD, 32'h8000_0040);
		pulse(m);
		st(3'h6);
		chk("held before mark", 32'h0, 32'(rd_v[cctm_pkg::ST_READY]));
		pulse(16'h1);
		st(3'h6);
		chk("sent at mark", 32'h1, 32'(rd_v[cctm_pkg::ST_READY]));
		chk("stamp inactive", 32'h0, 32'(rd_v[15:0]));
		inject(3'h7, d);
		rd(cctm_pkg::OFS_FREE_CNT);
		chk("counter resync", 32'h0, rd_v);
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h0000_00a0);
		lose <= 1'b1;
		wr(cctm_pkg::OFS_XFER_CMD, 32'h0000_0040);
		pulse(m + 16'h1);
		st(3'h6);
		chk("abort and ready", 32'h3, 32'({rd_v[cctm_pkg::ST_READY], rd_v[cctm_pkg::ST_ABORT]}));
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h1 << cctm_pkg::CM_TIME_TRIG);
		wr(cctm_pkg::OFS_XFER_CMD, 32'h8000_0040);
		pulse(m + 16'h1);
		st(3'h6);
		lose <= 1'b0;
		st(3'h6);
		chk("no early retry", 32'h0, 32'(rd_v[cctm_pkg::ST_READY]));
		wr(cctm_pkg::OFS_XFER_CMD, 32'h8000_0000);
		pulse(m + 16'h1);
		st(3'h6);
		chk("retry at mark", 32'h1, 32'(rd_v[cctm_pkg::ST_READY]));
		wr(cctm_pkg::OFS_IRQ_EN, 32'h1 << cctm_pkg::IRQ_FROZEN);
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h1 << cctm_pkg::CM_FREEZE);
		wr(cctm_pkg::OFS_XFER_CMD, 32'h8000_0000);
		pulse(16'hffff);
		pulse(16'h2);
		rd(cctm_pkg::OFS_FREE_CNT);
		chk("frozen value", 32'(cctm_pkg::CNT_MAX), rd_v);
		chk("frozen irq", 32'h1, 32'(can_irq));
		rd(cctm_pkg::OFS_CTRL_STAT);
		chk("frozen flag", 32'h1, 32'(rd_v[cctm_pkg::IRQ_FROZEN]));
		rd(cctm_pkg::OFS_CTRL_STAT);
		chk("flag cleared", 32'h0, 32'(rd_v[cctm_pkg::IRQ_FROZEN]));
		chk("irq cleared", 32'h0, 32'(can_irq));
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h0);
		pulse(16'h3);
		rd(cctm_pkg::OFS_FREE_CNT);
		chk("wrap", 32'h2, rd_v);
		// ticks run through a whole frame: twelve ticks in all, five before end of frame
		wr(cctm_pkg::OFS_CTRL_MODE, 32'h1 << cctm_pkg::CM_CAP_END);
		tick_en <= 1'b1;
		inject(3'h7, d);
		tick_en <= 1'b0;
		rd(cctm_pkg::OFS_FREE_CNT);
		chk("ticks over frame", 32'h0000_000e, rd_v);
		rd(cctm_pkg::OFS_STAMP);
		chk("stamp at frame end", 32'h0000_0007, rd_v);
		end_of_test();
	end
endmodule : can_consumer_and_timing_modes_tb_top
